// ### design/sensor_seq_dev.sv
`timescale 1ns/1ps
`include "seq_map.svh"
// What this block does
// - host holds select high, shutdown low, spi-high
// - reset by pin pulse or soft write
// - host reads part identifier after reset
// - host writes two init values, in order
// - two-wire: host sets address pins first
// - address latched only on reset pin toggle; the code also latches it when SRST ends, with no pin toggle
// - shutdown high reaches low current within limit
// - host keeps shutdown pulse long enough
// - no serial access while shutdown asserted
// - host waits after wake before access
// - registers survive shutdown unchanged
// - any reset returns registers to defaults
// - access valid within post-reset window
// - host holds reset pin low long enough
// - host waits after supply before reset
// - shutdown not for routine power saving
// - port-select low two-wire, high spi
// - select and data pins are address bits
module sensor_seq_dev #(
  parameter int unsigned SETTLE_CYC    = `SEQ_POST_RST_CYC,
  parameter int unsigned SHDN_LOW_CYC  = `SEQ_SHDN_LOW_CYC,
  parameter int unsigned REGS          = 256,
  parameter logic [7:0]  PART_ID       = 8'h5c  // arbitrary value
) (
  input  wire logic       CLK_SYS,
  input  wire logic       SRST,
  seq_if.dev              LINK,
  output logic            ACCESS_VALID,
  output logic            LOW_CURRENT,
  output logic            TWO_WIRE_MODE,
  output logic [1:0]      SLAVE_ADDR,
  output logic            ADDR_VALID
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // every flop of the block except the register array lives here
  typedef struct packed {
    logic [2:0]          rst_sync;   // reset pin synchroniser
    logic [2:0]          shdn_sync;  // shutdown pin synchroniser
    logic [2:0]          sel_sync;   // port-select synchroniser
    logic [2:0]          a0_sync;    // address bit 0 synchroniser
    logic [2:0]          a1_sync;    // address bit 1 synchroniser
    logic                rst_lvl;    // debounced reset pin level
    logic                shdn_lvl;   // debounced shutdown level
    seq_pkg::dev_state_t st;         // operating phase
    logic [31:0]         cnt;        // phase timer
    logic [1:0]          addr;       // latched two-wire address
    logic                addr_ok;    // address latched since power-up
    logic                two_wire;   // interface mode
    logic                done;       // access answered
    logic                ok;         // access accepted
    logic [7:0]          rdata;      // read data
  } st_t;
  st_t s_q;  // registered state
  st_t s_d;  // next state
  // register array is kept outside the struct; too wide to pack sensibly
  logic [7:0] regs_q [REGS];
  logic       regs_clr;   // reset every register to default
  logic       regs_we;    // accepted write
  // the low-current limit runs from the pin edge, so the cycles spent in the
  // synchroniser come off the countdown; below that latency it cannot be met
  localparam int unsigned SHDN_RUN_CYC = (SHDN_LOW_CYC > `SEQ_SYNC_LAT_CYC) ?
                                         SHDN_LOW_CYC - `SEQ_SYNC_LAT_CYC : 0;
  // agreement of second and third stage counts as a settled change
  function automatic logic agreed(input logic [2:0] sy, input logic prev);
    agreed = (sy[1] == sy[2]) ? sy[2] : prev;
  endfunction
  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // synchronisers always shift; the phase machine reads settled levels only
  always_comb begin
    s_d = s_q;
    regs_clr = 1'b0;
    regs_we  = 1'b0;
    s_d.rst_sync  = {s_q.rst_sync[1:0], LINK.hard_reset_n_in};
    s_d.shdn_sync = {s_q.shdn_sync[1:0], LINK.shutdown_in};
    s_d.sel_sync  = {s_q.sel_sync[1:0], LINK.port_select_in};
    s_d.a0_sync   = {s_q.a0_sync[1:0], LINK.serial_in_or_addr_bit0};
    s_d.a1_sync   = {s_q.a1_sync[1:0], LINK.chip_select_or_addr_bit1};
    s_d.rst_lvl   = agreed(s_q.rst_sync, s_q.rst_lvl);
    s_d.shdn_lvl  = agreed(s_q.shdn_sync, s_q.shdn_lvl);
    s_d.two_wire  = ~agreed(s_q.sel_sync, ~s_q.two_wire);
    s_d.done = 1'b0;
    s_d.ok   = 1'b0;
    // one shared phase timer, it rests at zero
    if (s_q.cnt != 32'h0) begin
      s_d.cnt = s_q.cnt - 32'h1;
    end
    // any access gets exactly one answer; ok only when running
    if (LINK.acc_valid) begin
      s_d.done = 1'b1;
    end
    case (s_q.st)
      seq_pkg::DEV_IN_RESET: begin
        // registers stay at defaults for as long as the pin is low
        regs_clr = 1'b1;
        if (s_q.rst_lvl) begin
          // address pins are sampled when the settled reset level rises, after a pin pulse or when SRST ends
          s_d.addr    = {agreed(s_q.a1_sync, s_q.addr[1]),
                         agreed(s_q.a0_sync, s_q.addr[0])};
          s_d.addr_ok = 1'b1;
          s_d.st      = seq_pkg::DEV_SETTLE;
          s_d.cnt     = SETTLE_CYC;
        end
      end
      seq_pkg::DEV_SETTLE: begin
        // requests here are answered but refused, nothing stored
        // timer was loaded on entry, from either kind of reset
        if (s_q.cnt == 32'h0) begin
          s_d.st = seq_pkg::DEV_RUN;
        end
      end
      seq_pkg::DEV_RUN: begin
        // shutdown wins over a request in the same cycle
        if (s_q.shdn_lvl) begin
          s_d.st  = seq_pkg::DEV_SHDN_ENTER;
          s_d.cnt = SHDN_RUN_CYC;
        end else if (LINK.acc_valid) begin
          s_d.ok = 1'b1;
          if (LINK.acc_write) begin
            // only the key value resets; other writes there are stored
            if (LINK.acc_addr == `SEQ_SOFT_RESET_ADDR &&
                LINK.acc_wdata == `SEQ_SOFT_RESET_VAL) begin
              // soft reset: registers cleared, address kept
              regs_clr = 1'b1;
              s_d.st   = seq_pkg::DEV_SETTLE;
              s_d.cnt  = SETTLE_CYC;
            end else begin
              regs_we = 1'b1;
            end
          end else if (LINK.acc_addr == `SEQ_PID_ADDR) begin
            // identifier is fixed, not held in the array
            s_d.rdata = PART_ID;
          end else begin
            s_d.rdata = regs_q[LINK.acc_addr];
          end
        end
      end
      seq_pkg::DEV_SHDN_ENTER: begin
        // register array is untouched for the whole sleep
        if (!s_q.shdn_lvl) begin
          s_d.st = seq_pkg::DEV_RUN;
        end else if (s_q.cnt == 32'h0) begin
          s_d.st = seq_pkg::DEV_SHDN_LOW;
        end
      end
      seq_pkg::DEV_SHDN_LOW: begin
        // waking resumes with contents intact; host owes the wake wait
        if (!s_q.shdn_lvl) begin
          s_d.st = seq_pkg::DEV_RUN;
        end
      end
      default: begin
        s_d.st = seq_pkg::DEV_IN_RESET;
      end
    endcase
    // a low reset pin overrides every phase
    // placed after the case so that no phase can escape it
    if (!s_q.rst_lvl) begin
      s_d.st  = seq_pkg::DEV_IN_RESET;
      s_d.cnt = 32'h0;
    end
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      s_q <= '0;
      s_q.rst_sync <= 3'b000;
      s_q.st       <= seq_pkg::DEV_IN_RESET;
    end else begin
      s_q <= s_d;
    end
  end
  // register array: defaults are zero, cleared by any reset
  // clearing all entries in one cycle costs area but keeps resets short
  always_ff @(posedge CLK_SYS) begin
    if (SRST || regs_clr) begin
      for (int i = 0; i < REGS; i++) begin
        regs_q[i] <= 8'h00;
      end
    end else if (regs_we) begin
      regs_q[LINK.acc_addr] <= LINK.acc_wdata;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // handshake and status outputs come straight from state flops
  assign LINK.acc_done  = s_q.done;
  assign LINK.acc_ok    = s_q.ok;
  assign LINK.acc_rdata = s_q.rdata;
  assign ACCESS_VALID   = (s_q.st == seq_pkg::DEV_RUN);
  assign LOW_CURRENT    = (s_q.st == seq_pkg::DEV_SHDN_LOW);
  assign TWO_WIRE_MODE  = s_q.two_wire;
  assign SLAVE_ADDR     = s_q.addr;
  // the latched address only means something in two-wire mode
  assign ADDR_VALID     = s_q.addr_ok & s_q.two_wire;
endmodule

// ### design/sensor_seq_host.sv
`timescale 1ns/1ps
`include "seq_map.svh"
module sensor_seq_host #(
  parameter int unsigned SUPPLY_CYC = `SEQ_SUPPLY_WAIT_CYC,
  parameter int unsigned RSTP_CYC   = `SEQ_RST_PULSE_CYC,
  parameter int unsigned SETTLE_CYC = `SEQ_POST_RST_CYC,
  parameter int unsigned SHDN_CYC   = `SEQ_SHDN_PULSE_CYC,
  parameter int unsigned WAKE_CYC   = `SEQ_WAKE_CYC,
  parameter logic [7:0]  PART_ID    = 8'h5c  // arbitrary value
) (
  input  wire logic       CLK_SYS,
  input  wire logic       SRST,
  seq_if.host             LINK,
  input  wire logic       USE_TWO_WIRE,
  input  wire logic [1:0] ADDR_SEL,
  input  wire logic       SLEEP_REQ,
  output logic            READY,
  output logic            FAILED
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    seq_pkg::host_state_t st;   // sequencing phase
    logic [31:0]          cnt;  // phase timer
    logic                 rstn; // reset pin drive
    logic                 shdn; // shutdown pin drive
    logic                 req;  // access request
    logic                 wr;   // write flag
    logic [7:0]           addr; // address
    logic [7:0]           wd;   // write data
  } st_t;
  st_t s_q;  // registered state
  st_t s_d;  // next state
  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.req = 1'b0;
    if (s_q.cnt != 32'h0) begin
      s_d.cnt = s_q.cnt - 32'h1;
    end
    case (s_q.st)
      seq_pkg::HOST_SUPPLY_WAIT: begin
        if (s_q.cnt == 32'h0) begin
          s_d.st   = seq_pkg::HOST_RST_LOW;
          s_d.rstn = 1'b0;
          s_d.cnt  = RSTP_CYC;
        end
      end
      seq_pkg::HOST_RST_LOW: begin
        if (s_q.cnt == 32'h0) begin
          s_d.st   = seq_pkg::HOST_SETTLE;
          s_d.rstn = 1'b1;
          s_d.cnt  = SETTLE_CYC;
        end
      end
      seq_pkg::HOST_SETTLE: begin
        if (s_q.cnt == 32'h0) begin
          s_d.st = seq_pkg::HOST_READ_PID;
        end
      end
      seq_pkg::HOST_READ_PID: begin
        s_d.req  = 1'b1;
        s_d.wr   = 1'b0;
        s_d.addr = `SEQ_PID_ADDR;
        s_d.st   = seq_pkg::HOST_WAIT_PID;
      end
      seq_pkg::HOST_WAIT_PID: begin
        if (LINK.acc_done) begin
          if (!LINK.acc_ok) begin
            s_d.st = seq_pkg::HOST_READ_PID;            // retry early refusal
          end else if (LINK.acc_rdata == PART_ID) begin
            s_d.st   = seq_pkg::HOST_WR_INIT1;
            s_d.req  = 1'b1;
            s_d.wr   = 1'b1;
            s_d.addr = `SEQ_INIT1_ADDR;
            s_d.wd   = `SEQ_INIT1_VAL;
          end else begin
            s_d.st = seq_pkg::HOST_FAIL;
          end
        end
      end
      seq_pkg::HOST_WR_INIT1: begin
        if (LINK.acc_done) begin
          s_d.st   = seq_pkg::HOST_WR_INIT2;
          s_d.req  = 1'b1;
          s_d.addr = `SEQ_INIT2_ADDR;
          s_d.wd   = `SEQ_INIT2_VAL;
        end
      end
      seq_pkg::HOST_WR_INIT2: begin
        if (LINK.acc_done) begin
          s_d.st = seq_pkg::HOST_READY;
        end
      end
      seq_pkg::HOST_READY: begin
        // sleep only on explicit request, not for idle saving
        if (SLEEP_REQ) begin
          s_d.st   = seq_pkg::HOST_SHDN_HOLD;
          s_d.shdn = 1'b1;
          s_d.cnt  = SHDN_CYC;
        end
      end
      seq_pkg::HOST_SHDN_HOLD: begin
        // no accesses issued while asleep
        if (s_q.cnt == 32'h0 && !SLEEP_REQ) begin
          s_d.st   = seq_pkg::HOST_WAKE_WAIT;
          s_d.shdn = 1'b0;
          s_d.cnt  = WAKE_CYC;
        end
      end
      seq_pkg::HOST_WAKE_WAIT: begin
        if (s_q.cnt == 32'h0) begin
          s_d.st = seq_pkg::HOST_READY;
        end
      end
      default: begin
        s_d.st = seq_pkg::HOST_FAIL;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      s_q      <= '0;
      s_q.st   <= seq_pkg::HOST_SUPPLY_WAIT;
      s_q.rstn <= 1'b1;
      s_q.cnt  <= SUPPLY_CYC;
    end else begin
      s_q <= s_d;
    end
  end
  // ----------------------------------------------------------------
  // pins: select high, shutdown low, mode per user
  // ----------------------------------------------------------------
  assign LINK.hard_reset_n_in          = s_q.rstn;
  assign LINK.shutdown_in              = s_q.shdn;
  assign LINK.port_select_in           = ~USE_TWO_WIRE;
  assign LINK.chip_select_or_addr_bit1 = USE_TWO_WIRE ? ADDR_SEL[1] : 1'b1;
  assign LINK.serial_in_or_addr_bit0   = USE_TWO_WIRE ? ADDR_SEL[0] : 1'b0;
  assign LINK.acc_valid                = s_q.req;
  assign LINK.acc_write                = s_q.wr;
  assign LINK.acc_addr                 = s_q.addr;
  assign LINK.acc_wdata                = s_q.wd;
  assign READY                         = (s_q.st == seq_pkg::HOST_READY);
  assign FAILED                        = (s_q.st == seq_pkg::HOST_FAIL);
endmodule

// ### pkg/seq_if.sv
`timescale 1ns/1ps
// pins between host and sensor, plus a simple register access channel
interface seq_if;
  logic       hard_reset_n_in;          // reset pin, low resets
  logic       shutdown_in;              // shutdown pin, high sleeps
  logic       port_select_in;           // high spi, low two-wire
  logic       chip_select_or_addr_bit1; // spi select or address bit 1
  logic       serial_in_or_addr_bit0;   // spi data in or address bit 0
  logic       acc_valid;                // register access request
  logic       acc_write;                // 1 write, 0 read
  logic [7:0] acc_addr;                 // register address
  logic [7:0] acc_wdata;                // write data
  logic       acc_done;                 // access answered, one cycle
  logic       acc_ok;                   // access accepted (not ignored)
  logic [7:0] acc_rdata;                // read data
  modport dev (
    input  hard_reset_n_in, shutdown_in, port_select_in,
    input  chip_select_or_addr_bit1, serial_in_or_addr_bit0,
    input  acc_valid, acc_write, acc_addr, acc_wdata,
    output acc_done, acc_ok, acc_rdata
  );
  modport host (
    output hard_reset_n_in, shutdown_in, port_select_in,
    output chip_select_or_addr_bit1, serial_in_or_addr_bit0,
    output acc_valid, acc_write, acc_addr, acc_wdata,
    input  acc_done, acc_ok, acc_rdata
  );
endinterface

// ### pkg/seq_map.svh
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH
// ----------------------------------------------------------------
// register addresses and values used by reset and initialisation
// ----------------------------------------------------------------
`define SEQ_SOFT_RESET_ADDR  8'h3a
`define SEQ_SOFT_RESET_VAL   8'h5a
`define SEQ_PID_ADDR         8'h00
`define SEQ_INIT1_ADDR       8'h60
`define SEQ_INIT1_VAL        8'he4
`define SEQ_INIT2_ADDR       8'h61
`define SEQ_INIT2_VAL        8'hc9
// ----------------------------------------------------------------
// times in their own units, and clock rate
// ----------------------------------------------------------------
`define SEQ_CLK_HZ           50000000
`define SEQ_POST_RST_MIN_US  3500
`define SEQ_POST_RST_MAX_US  23000
`define SEQ_SHDN_LOW_MAX_MS  50
`define SEQ_SHDN_PULSE_MS    150
`define SEQ_WAKE_MS          100
`define SEQ_RST_PULSE_US     20
`define SEQ_SUPPLY_WAIT_MS   100
// ----------------------------------------------------------------
// cycle counts (rate per unit truncates first, so every time rounds down)
// ----------------------------------------------------------------
`define SEQ_CYC_US(t)        ((`SEQ_CLK_HZ / 1000000) * (t))
`define SEQ_CYC_MS(t)        ((`SEQ_CLK_HZ / 1000) * (t))
`define SEQ_POST_RST_CYC     `SEQ_CYC_US(`SEQ_POST_RST_MIN_US)
`define SEQ_SHDN_LOW_CYC     `SEQ_CYC_MS(`SEQ_SHDN_LOW_MAX_MS)
`define SEQ_SHDN_PULSE_CYC   `SEQ_CYC_MS(`SEQ_SHDN_PULSE_MS)
`define SEQ_WAKE_CYC         `SEQ_CYC_MS(`SEQ_WAKE_MS)
`define SEQ_RST_PULSE_CYC    `SEQ_CYC_US(`SEQ_RST_PULSE_US)
`define SEQ_SUPPLY_WAIT_CYC  `SEQ_CYC_MS(`SEQ_SUPPLY_WAIT_MS)
// pin edge to phase change: three synchroniser stages, level filter, step
`define SEQ_SYNC_LAT_CYC     6
`endif

// ### pkg/seq_pkg.sv
package seq_pkg;
  // device operating phase
  typedef enum logic [2:0] {
    DEV_IN_RESET,
    DEV_SETTLE,
    DEV_RUN,
    DEV_SHDN_ENTER,
    DEV_SHDN_LOW
  } dev_state_t;
  // host sequencing phase
  typedef enum logic [3:0] {
    HOST_SUPPLY_WAIT,
    HOST_RST_LOW,
    HOST_SETTLE,
    HOST_READ_PID,
    HOST_WAIT_PID,
    HOST_WR_INIT1,
    HOST_WR_INIT2,
    HOST_READY,
    HOST_SHDN_HOLD,
    HOST_WAKE_WAIT,
    HOST_FAIL
  } host_state_t;
endpackage

// ### testbench/seq_props.sv
`timescale 1ns/1ps
`include "seq_map.svh"
// ----------------------------------------
// link checks between host and sensor ends
// ----------------------------------------
module seq_props #(
  parameter int unsigned SUPPLY_CYC = 10,
  parameter int unsigned WAKE_CYC   = 10,
  parameter logic [7:0]  PART_ID    = 8'h5c  // arbitrary value
) (
  input wire logic       CLK_SYS,
  input wire logic       SRST,
  input wire logic       hard_reset_n_in,
  input wire logic       shutdown_in,
  input wire logic       port_select_in,
  input wire logic       chip_select_or_addr_bit1,
  input wire logic       serial_in_or_addr_bit0,
  input wire logic       acc_valid,
  input wire logic       acc_write,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic       acc_done,
  input wire logic       acc_ok,
  input wire logic [7:0] acc_rdata
);
  logic [15:0] up_q;   // cycles since sync reset, saturating
  logic [15:0] wake_q; // cycles since shutdown fell, saturating
  // counters saturate so long runs never wrap into a false wait
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      up_q   <= 16'h0000;
      wake_q <= 16'hffff;
    end else begin
      if (up_q != 16'hffff) up_q <= up_q + 16'h0001;
      if (shutdown_in) wake_q <= 16'h0000;
      else if (wake_q != 16'hffff) wake_q <= wake_q + 16'h0001;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  a_done_next: assert property (acc_valid |=> acc_done)
    else $error("request not answered next cycle");
  a_done_cause: assert property (acc_done |-> $past(acc_valid))
    else $error("answer without request");
  a_quiet_shdn: assert property (shutdown_in |-> !acc_valid)
    else $error("access while shutdown high");
  a_quiet_reset: assert property (!hard_reset_n_in |-> !acc_valid)
    else $error("access while reset pin low");
  a_reset_width: assert property ($fell(hard_reset_n_in) |-> !hard_reset_n_in[*5])
    else $error("reset pulse too short");
  a_shdn_width: assert property ($rose(shutdown_in) |-> shutdown_in[*8] ##1 shutdown_in[*2])
    else $error("shutdown pulse too short");
  a_wake_wait: assert property (acc_valid |-> wake_q >= WAKE_CYC - 1)
    else $error("access too soon after wake");
  a_supply_wait: assert property ($fell(hard_reset_n_in) |-> up_q >= SUPPLY_CYC - 1)
    else $error("reset pulse too soon after power");
  a_reset_pins: assert property (!hard_reset_n_in |->
    !shutdown_in && (!port_select_in || chip_select_or_addr_bit1))
    else $error("pins wrong during reset");
  a_init_values: assert property (acc_valid && acc_write && acc_addr == `SEQ_INIT2_ADDR
    |-> acc_wdata == `SEQ_INIT2_VAL)
    else $error("second init value wrong");
  a_pid_read: assert property (acc_done && acc_ok && !$past(acc_write)
    && $past(acc_addr) == `SEQ_PID_ADDR |-> acc_rdata == PART_ID)
    else $error("part identifier wrong");
  c_write_ok: cover property (acc_done && acc_ok && $past(acc_write));
  c_sleep: cover property ($rose(shutdown_in));
  c_reset: cover property ($rose(hard_reset_n_in));
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
`include "seq_map.svh"
module testbench;
  localparam int SET_B = 20;                 // shortened settle count
  localparam int MAX_B = SET_B * 23000 / 3500; // latest valid access
  localparam int SUP_B  = 10;                // shortened supply wait
  localparam int RSTP_B = 5;                 // shortened reset pulse
  localparam int SHDN_B = 10;                // shortened shutdown pulse
  localparam int WAKE_B = 10;                // shortened wake wait
  localparam int LOWC_B = 10;                // shortened low-current limit
  logic       clk_sys, srst, two_wire, sleep_req;
  logic [1:0] addr_sel, sa_a, sa_b;
  logic       ready_a, failed_a, accv_a, lowc_a, twm_a, addrv_a;
  logic       accv_b, lowc_b, twm_b, addrv_b;
  logic [3:0] flg;
  int         n_fail = 0, num_checks = 0, cyc = 0, t0 = 0;
  assign flg = {lowc_a, ready_a, lowc_b, accv_b};
  seq_if link_a();
  seq_if link_b();
  sensor_seq_host #(.SUPPLY_CYC(SUP_B), .RSTP_CYC(RSTP_B), .SETTLE_CYC(SET_B),
    .SHDN_CYC(SHDN_B), .WAKE_CYC(WAKE_B)) i_sensor_seq_host (.CLK_SYS(clk_sys), .SRST(srst),
    .LINK(link_a),
    .USE_TWO_WIRE(two_wire), .ADDR_SEL(addr_sel), .SLEEP_REQ(sleep_req),
    .READY(ready_a), .FAILED(failed_a));
  sensor_seq_dev #(.SETTLE_CYC(SET_B), .SHDN_LOW_CYC(LOWC_B)) i_sensor_seq_dev (
    .CLK_SYS(clk_sys), .SRST(srst), .LINK(link_a), .ACCESS_VALID(accv_a),
    .LOW_CURRENT(lowc_a), .TWO_WIRE_MODE(twm_a), .SLAVE_ADDR(sa_a), .ADDR_VALID(addrv_a));
  // second sensor, driven straight from the bench so faults can be forced
  sensor_seq_dev #(.SETTLE_CYC(SET_B), .SHDN_LOW_CYC(LOWC_B)) i_sensor_seq_dev_b (
    .CLK_SYS(clk_sys), .SRST(srst), .LINK(link_b), .ACCESS_VALID(accv_b),
    .LOW_CURRENT(lowc_b), .TWO_WIRE_MODE(twm_b), .SLAVE_ADDR(sa_b), .ADDR_VALID(addrv_b));
  seq_props #(.SUPPLY_CYC(SUP_B), .WAKE_CYC(WAKE_B)) i_seq_props (.CLK_SYS(clk_sys),
    .SRST(srst),
    .hard_reset_n_in(link_a.hard_reset_n_in), .shutdown_in(link_a.shutdown_in),
    .port_select_in(link_a.port_select_in),
    .chip_select_or_addr_bit1(link_a.chip_select_or_addr_bit1),
    .serial_in_or_addr_bit0(link_a.serial_in_or_addr_bit0), .acc_valid(link_a.acc_valid),
    .acc_write(link_a.acc_write), .acc_addr(link_a.acc_addr), .acc_wdata(link_a.acc_wdata),
    .acc_done(link_a.acc_done), .acc_ok(link_a.acc_ok), .acc_rdata(link_a.acc_rdata));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one access on the second sensor; answer is due the cycle after the request
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic ok, input logic [7:0] rd);
    int n = 0;
    @(posedge clk_sys);
    link_b.acc_valid <= 1'b1;
    link_b.acc_write <= w;
    link_b.acc_addr  <= a;
    link_b.acc_wdata <= d;
    @(posedge clk_sys);
    link_b.acc_valid <= 1'b0;
    #1;
    while (link_b.acc_done !== 1'b1 && n < 4) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(8'(link_b.acc_done), 8'h01, "answer given");
    chk(8'(link_b.acc_ok), 8'(ok), "access accepted");
    if (!w && ok) chk(link_b.acc_rdata, rd, "read data");
  endtask
  task automatic wait_for(input int idx, input int lim);
    int n = 0;
    // let the edge that launched the last change settle first
    @(posedge clk_sys);
    #1;
    while (flg[idx] !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= lim) chk(8'h00, 8'h01, "wait limit");
  endtask
  task automatic pulse_b(input logic [1:0] a);
    @(posedge clk_sys);
    link_b.chip_select_or_addr_bit1 <= a[1];
    link_b.serial_in_or_addr_bit0   <= a[0];
    link_b.hard_reset_n_in          <= 1'b0;
    repeat (RSTP_B) @(posedge clk_sys); // hold low long enough
    link_b.hard_reset_n_in <= 1'b1;
    t0 = cyc;
  endtask
  // hang guard: far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      close_out;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {srst, two_wire, sleep_req, addr_sel} = 5'h10;
    link_b.hard_reset_n_in = 1'b1;
    link_b.shutdown_in = 1'b0;
    link_b.port_select_in = 1'b0;
    {link_b.chip_select_or_addr_bit1, link_b.serial_in_or_addr_bit0} = 2'h0;
    {link_b.acc_valid, link_b.acc_write, link_b.acc_addr, link_b.acc_wdata} = 18'h0;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    pulse_b(2'b01);
    acc(1'b0, `SEQ_PID_ADDR, 8'h00, 1'b0, 8'h00);
    acc(1'b1, `SEQ_INIT1_ADDR, `SEQ_INIT1_VAL, 1'b0, 8'h00);
    wait_for(0, 200);
    chk(8'(cyc - t0 >= SET_B && cyc - t0 <= MAX_B), 8'h01, "settle time");
    chk(8'(twm_b), 8'h01, "two-wire mode");
    chk({6'h00, sa_b}, 8'h01, "latched address");
    chk(8'(addrv_b), 8'h01, "address valid");
    acc(1'b0, `SEQ_PID_ADDR, 8'h00, 1'b1, 8'h5c);
    acc(1'b0, `SEQ_INIT1_ADDR, 8'h00, 1'b1, 8'h00);
    acc(1'b1, `SEQ_INIT1_ADDR, `SEQ_INIT1_VAL, 1'b1, 8'h00);
    acc(1'b1, `SEQ_INIT2_ADDR, `SEQ_INIT2_VAL, 1'b1, 8'h00);
    acc(1'b0, `SEQ_INIT1_ADDR, 8'h00, 1'b1, `SEQ_INIT1_VAL);
    // sleep and wake keep the written values
    @(posedge clk_sys);
    link_b.shutdown_in <= 1'b1;
    t0 = cyc + 1; // cyc still shows the count before this edge
    wait_for(1, 40);
    chk(8'(cyc - t0 <= LOWC_B), 8'h01, "low current time");
    acc(1'b0, `SEQ_INIT1_ADDR, 8'h00, 1'b0, 8'h00);
    repeat (SHDN_B) @(posedge clk_sys);
    link_b.shutdown_in <= 1'b0;
    repeat (WAKE_B) @(posedge clk_sys);
    wait_for(0, 40);
    acc(1'b0, `SEQ_INIT2_ADDR, 8'h00, 1'b1, `SEQ_INIT2_VAL);
    // soft reset clears registers but keeps the address
    @(posedge clk_sys);
    {link_b.chip_select_or_addr_bit1, link_b.serial_in_or_addr_bit0} <= 2'b10;
    acc(1'b1, `SEQ_SOFT_RESET_ADDR, `SEQ_SOFT_RESET_VAL, 1'b1, 8'h00);
    acc(1'b0, `SEQ_INIT1_ADDR, 8'h00, 1'b0, 8'h00);
    wait_for(0, 200);
    acc(1'b0, `SEQ_INIT1_ADDR, 8'h00, 1'b1, 8'h00);
    chk({6'h00, sa_b}, 8'h01, "address kept");
    acc(1'b1, `SEQ_INIT2_ADDR, `SEQ_INIT2_VAL, 1'b1, 8'h00);
    pulse_b(2'b10);
    wait_for(0, 200);
    acc(1'b0, `SEQ_INIT2_ADDR, 8'h00, 1'b1, 8'h00);
    chk({6'h00, sa_b}, 8'h02, "relatched address");
    @(posedge clk_sys);
    link_b.port_select_in <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    chk(8'(twm_b), 8'h00, "spi mode");
    // host and sensor pair ran their own start-up meanwhile
    chk(8'(ready_a), 8'h01, "host ready");
    chk(8'(failed_a), 8'h00, "identifier match");
    chk(8'(twm_a), 8'h00, "pair spi");
    @(posedge clk_sys);
    sleep_req <= 1'b1;
    wait_for(3, 60);
    @(posedge clk_sys);
    sleep_req <= 1'b0;
    wait_for(2, 300);
    chk(8'(accv_a), 8'h01, "pair awake");
    // second reset brings the pair up in two-wire mode
    @(posedge clk_sys);
    {srst, two_wire, addr_sel} <= 4'hf;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    wait_for(2, 300);
    chk(8'(twm_a), 8'h01, "pair two-wire");
    chk({6'h00, sa_a}, 8'h03, "pair address");
    chk(8'(addrv_a), 8'h01, "pair address valid");
    close_out;
  end
endmodule
